// >>> logic/led_sink_blink_control.sv
// LED channel two blink and enable control with its two configuration registers
`timescale 1ns/1ps
`include "led_sink_map.svh"

module led_sink_blink_control #(
  parameter int ROOT_CYCLES = `LED_ROOT_CYCLES,
  parameter int TICKS_PER_STEP = `LED_TICKS_PER_STEP
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic sinkMasterEnable,
  input wire logic controllerOn,
  output logic sinkOn,
  output logic [1:0] chanTwoRangeCode,
  output logic chanTwoPhaseInvert,
  output logic [4:0] chanTwoBrightnessCode,
  output logic [3:0] chanTwoPeriodCode,
  output logic [3:0] chanTwoDutyCode,
  output logic rootClockStatus
);
  localparam int HIGH_CYCLES = (ROOT_CYCLES * `LED_ROOT_HIGH_PCT) / 100;

  ////////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [7:0] rangeBright;
  logic [7:0] periodDuty;
  logic [7:0] next_rangeBright;
  logic [7:0] next_periodDuty;
  logic [7:0] next_regRdData;

  // Write decode and registered read answer; unmapped reads return zero
  always_comb begin
    next_rangeBright = rangeBright;
    next_periodDuty = periodDuty;
    next_regRdData = regRdData;
    if (regWrite && regAddr == `LED_ADDR_RANGE_BRIGHT) begin
      next_rangeBright = regWrData;
    end else if (regWrite && regAddr == `LED_ADDR_PERIOD_DUTY) begin
      next_periodDuty = regWrData;
    end
    if (regRead) begin
      if (regAddr == `LED_ADDR_RANGE_BRIGHT) begin
        next_regRdData = rangeBright;
      end else if (regAddr == `LED_ADDR_PERIOD_DUTY) begin
        next_regRdData = periodDuty;
      end else begin
        next_regRdData = 8'h00;
      end
    end
  end

  // Register storage with reset defaults
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rangeBright <= `LED_RESET_RANGE_BRIGHT;
      periodDuty <= `LED_RESET_PERIOD_DUTY;
      regRdData <= 8'h00;
    end else begin
      rangeBright <= next_rangeBright;
      periodDuty <= next_periodDuty;
      regRdData <= next_regRdData;
    end
  end

  // Field outputs straight from the register flops
  assign chanTwoRangeCode = rangeBright[`LED_RANGE_MSB:`LED_RANGE_LSB];
  assign chanTwoPhaseInvert = rangeBright[`LED_INVERT_BIT];
  assign chanTwoBrightnessCode = rangeBright[`LED_BRIGHT_MSB:`LED_BRIGHT_LSB];
  assign chanTwoPeriodCode = periodDuty[`LED_PERIOD_MSB:`LED_PERIOD_LSB];
  assign chanTwoDutyCode = periodDuty[`LED_DUTY_MSB:`LED_DUTY_LSB];

  ////////////////////////////////////////////////////////////////////////////////
  // 64Hz root clock divider

  logic [31:0] divCount;
  logic [31:0] next_divCount;
  logic rootTick;
  logic next_rootTick;
  logic next_rootClockStatus;

  // One tick pulse per root period; status is high for the first tenth
  always_comb begin
    next_divCount = (divCount == 32'(ROOT_CYCLES - 1)) ? 32'h00000000 : divCount + 32'h00000001;
    next_rootTick = (next_divCount == 32'h00000000);
    next_rootClockStatus = (next_divCount < 32'(HIGH_CYCLES));
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      divCount <= 32'h00000000;
      rootTick <= 1'b0;
      rootClockStatus <= 1'b0;
    end else begin
      divCount <= next_divCount;
      rootTick <= next_rootTick;
      rootClockStatus <= next_rootClockStatus;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Blink sequencer

  logic channelOn;
  logic [9:0] tickCount;
  logic [3:0] livePeriod;
  logic [3:0] liveDuty;
  logic liveInvert;
  logic [9:0] periodTicks;
  logic [9:0] dutyTicks;
  logic [9:0] next_tickCount;
  logic [3:0] next_livePeriod;
  logic [3:0] next_liveDuty;
  logic next_liveInvert;
  logic next_sinkOn;
  led_sink_pkg::phase_t phase;

  // Channel gate: own range, master enable and controller on state
  assign channelOn = (led_sink_pkg::range_t'(chanTwoRangeCode) != led_sink_pkg::RANGE_OFF)
    && sinkMasterEnable && controllerOn;
  assign periodTicks = 10'(({6'h00, livePeriod} + 10'h001) * 10'(TICKS_PER_STEP));
  // Product is formed at full width so long periods at full duty do not wrap
  assign dutyTicks = 10'(((32'(livePeriod) + 32'h00000001) * (32'(liveDuty) + 32'h00000001)
    * 32'(TICKS_PER_STEP)) >> 4);
  assign phase = (tickCount < dutyTicks) ? led_sink_pkg::PHASE_ACTIVE : led_sink_pkg::PHASE_REST;

  // Counter restarts at each boundary and settings are latched only there, or on every cycle while the channel is off
  always_comb begin
    next_tickCount = tickCount;
    next_livePeriod = livePeriod;
    next_liveDuty = liveDuty;
    next_liveInvert = liveInvert;
    if (!channelOn) begin
      // Latch the incoming values so a write that enables the channel starts with its own settings
      next_tickCount = 10'h000;
      next_livePeriod = next_periodDuty[`LED_PERIOD_MSB:`LED_PERIOD_LSB];
      next_liveDuty = next_periodDuty[`LED_DUTY_MSB:`LED_DUTY_LSB];
      next_liveInvert = next_rangeBright[`LED_INVERT_BIT];
    end else if (rootTick) begin
      if (tickCount == periodTicks - 10'h001) begin
        next_tickCount = 10'h000;
        next_livePeriod = chanTwoPeriodCode;
        next_liveDuty = chanTwoDutyCode;
        next_liveInvert = chanTwoPhaseInvert;
      end else begin
        next_tickCount = tickCount + 10'h001;
      end
    end
    next_sinkOn = 1'b0;
    if (channelOn) begin
      case (phase)
        led_sink_pkg::PHASE_ACTIVE: next_sinkOn = !liveInvert;
        led_sink_pkg::PHASE_REST: next_sinkOn = liveInvert;
        default: next_sinkOn = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tickCount <= 10'h000;
      livePeriod <= 4'h0;
      liveDuty <= 4'hF;
      liveInvert <= 1'b0;
      sinkOn <= 1'b0;
    end else begin
      tickCount <= next_tickCount;
      livePeriod <= next_livePeriod;
      liveDuty <= next_liveDuty;
      liveInvert <= next_liveInvert;
      sinkOn <= next_sinkOn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions and covers

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_range_off_dark;
    chanTwoRangeCode == 2'b00 |=> !sinkOn;
  endproperty
  a_range_off_dark: assert property (p_range_off_dark) else $error("sink on with range zero");

  property p_gate_needed;
    !(sinkMasterEnable && controllerOn) |=> !sinkOn;
  endproperty
  a_gate_needed: assert property (p_gate_needed) else $error("sink on without master or on state");

  property p_inphase_start;
    channelOn && !liveInvert && tickCount == 10'h000 && $stable(channelOn) |=> sinkOn;
  endproperty
  a_inphase_start: assert property (p_inphase_start) else $error("in-phase period did not start on");

  property p_invert_start;
    channelOn && liveInvert && tickCount < dutyTicks |=> !sinkOn;
  endproperty
  a_invert_start: assert property (p_invert_start) else $error("inverted period did not start off");

  property p_write_bright;
    regWrite && regAddr == `LED_ADDR_RANGE_BRIGHT |=> chanTwoBrightnessCode == $past(regWrData[4:0]);
  endproperty
  a_write_bright: assert property (p_write_bright) else $error("brightness code not stored");

  property p_reset_values;
    $rose(rst_n) |-> rangeBright == `LED_RESET_RANGE_BRIGHT;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("first register reset value wrong");

  property p_reset_second;
    $rose(rst_n) |-> periodDuty == `LED_RESET_PERIOD_DUTY;
  endproperty
  a_reset_second: assert property (p_reset_second) else $error("second register reset value wrong");

  property p_period_len;
    channelOn |-> tickCount < ({6'h00, livePeriod} + 10'h001) * 10'(TICKS_PER_STEP);
  endproperty
  a_period_len: assert property (p_period_len) else $error("period length decode wrong");

  property p_duty_full;
    channelOn && liveDuty == 4'hF && !liveInvert ##1 channelOn |-> sinkOn;
  endproperty
  a_duty_full: assert property (p_duty_full) else $error("full duty not continuously on");

  property p_tick_spacing;
    rootTick |=> !rootTick [*2];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("root ticks too close");

  property p_master_off;
    !sinkMasterEnable |=> !sinkOn;
  endproperty
  a_master_off: assert property (p_master_off) else $error("sink on with master clear");

  property p_hold_mid;
    channelOn && !(rootTick && tickCount == periodTicks - 10'h001) |=> $stable(livePeriod) && $stable(liveDuty);
  endproperty
  a_hold_mid: assert property (p_hold_mid) else $error("settings changed mid period");

  c_blink_on: cover property (channelOn && sinkOn);
  c_inverted: cover property (channelOn && liveInvert && sinkOn);
  c_boundary: cover property (channelOn && rootTick && tickCount == periodTicks - 10'h001);
  c_read_back: cover property (regRead && regAddr == `LED_ADDR_PERIOD_DUTY);

endmodule

// >>> logic/led_sink_map.svh
// Register map, field positions, reset values and timing counts of the LED channel two blink block
`ifndef LED_SINK_MAP_SVH
`define LED_SINK_MAP_SVH

`define LED_ADDR_RANGE_BRIGHT 8'h42
`define LED_ADDR_PERIOD_DUTY 8'h45
`define LED_RESET_RANGE_BRIGHT 8'h04
`define LED_RESET_PERIOD_DUTY 8'h0F
`define LED_RANGE_MSB 7
`define LED_RANGE_LSB 6
`define LED_INVERT_BIT 5
`define LED_BRIGHT_MSB 4
`define LED_BRIGHT_LSB 0
`define LED_PERIOD_MSB 7
`define LED_PERIOD_LSB 4
`define LED_DUTY_MSB 3
`define LED_DUTY_LSB 0
`define LED_SYS_CLK_HZ 250000000
`define LED_ROOT_HZ 64
`define LED_ROOT_HIGH_PCT 10
`define LED_HALF_PERIOD_MS 500
`define LED_ROOT_CYCLES (`LED_SYS_CLK_HZ / `LED_ROOT_HZ)
`define LED_TICKS_PER_STEP (`LED_HALF_PERIOD_MS * `LED_ROOT_HZ / 1000)

`endif

// >>> logic/led_sink_pkg.sv
// Types shared by the LED channel two blink block
package led_sink_pkg;
  typedef enum logic [1:0] {
    RANGE_OFF = 2'b00,
    RANGE_LOW = 2'b01,
    RANGE_MID = 2'b10,
    RANGE_HIGH = 2'b11
  } range_t;
  typedef enum logic {
    PHASE_ACTIVE = 1'b0,
    PHASE_REST = 1'b1
  } phase_t;
endpackage

// >>> verification/led_load_model.sv
// External LED load that totals the clock cycles during which it is lit
`timescale 1ns/1ps
module led_load_model (
  input wire logic sys_clk,
  input wire logic sinkOn,
  output int litCycles
);
  int count = 0;
  // Only a clean high level lights the LED; an unknown level stays dark
  always @(posedge sys_clk) begin
    if (sinkOn === 1'b1) begin
      count <= count + 1;
    end
  end
  assign litCycles = count;
endmodule

// >>> verification/led_sink_blink_control_tb.sv
// Self-checking bench for the LED channel two blink control
`timescale 1ns/1ps
module led_sink_blink_control_tb;
  localparam int RC = 10;
  localparam int TS = 16;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic sinkMasterEnable = 1'b1;
  logic controllerOn = 1'b1;
  logic [7:0] regRdData;
  logic sinkOn;
  logic chanTwoPhaseInvert;
  logic rootClockStatus;
  logic [1:0] chanTwoRangeCode;
  logic [4:0] chanTwoBrightnessCode;
  logic [3:0] chanTwoPeriodCode;
  logic [3:0] chanTwoDutyCode;
  int litCycles;
  int n_fail = 0;
  int n_tests = 0;
  // Rows: first register in the upper byte, second register in the lower byte
  logic [15:0] rows [7] = '{16'h4400, 16'h9F17, 16'hE503, 16'h6A2E, 16'h8C0F, 16'hF10F, 16'h1F1F};

  ////////////////////////////////////////////////////////////////////////////////
  led_sink_blink_control #(.ROOT_CYCLES(RC), .TICKS_PER_STEP(TS)) DUT (
    .sys_clk, .rst_n, .regWrite, .regRead, .regAddr, .regWrData, .regRdData,
    .sinkMasterEnable, .controllerOn, .sinkOn, .chanTwoRangeCode, .chanTwoPhaseInvert,
    .chanTwoBrightnessCode, .chanTwoPeriodCode, .chanTwoDutyCode, .rootClockStatus
  );
  led_load_model led (.sys_clk, .sinkOn, .litCycles);

  // Clock of 4 ns
  always #2 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    @(posedge sys_clk);
    #1 chk(regRdData, exp);
  endtask

  // Lit cycles seen by the load over a window of n cycles
  task automatic span(input int n, output int c);
    @(posedge sys_clk);
    #1 c = litCycles;
    repeat (n) @(posedge sys_clk);
    #1 c = litCycles - c;
  endtask

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Cut a hang short well beyond the expected run
  initial begin
    #200000;
    n_fail++;
    conclude();
  end

  initial begin
    int p;
    int on;
    int c;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(8'h42, 8'h04);
    rd(8'h45, 8'h0F);
    wr(8'h43, 8'hFF);
    rd(8'h43, 8'h00);
    rd(8'h42, 8'h04);
    // Root status high one cycle in every RC
    c = 0;
    repeat (10 * RC) begin
      @(posedge sys_clk);
      #1 c += (rootClockStatus === 1'b1);
    end
    chk(c, 10);
    // Table of blink settings
    foreach (rows[i]) begin
      wr(8'h42, 8'h00);
      wr(8'h45, rows[i][7:0]);
      wr(8'h42, rows[i][15:8]);
      @(posedge sys_clk);
      #1 chk(sinkOn, rows[i][15:14] != 2'b00 && !rows[i][13]);
      chk({chanTwoRangeCode, chanTwoPhaseInvert, chanTwoBrightnessCode}, rows[i][15:8]);
      chk({chanTwoPeriodCode, chanTwoDutyCode}, rows[i][7:0]);
      p = (int'(rows[i][7:4]) + 1) * TS * RC;
      on = (int'(rows[i][7:4]) + 1) * (int'(rows[i][3:0]) + 1) * RC;
      if (rows[i][13]) on = p - on;
      if (rows[i][15:14] == 2'b00) on = 0;
      span(p, c);
      span(p, c);
      chk(c, on);
      rd(8'h42, rows[i][15:8]);
      rd(8'h45, rows[i][7:0]);
    end
    // Master enable and controller state gate the sink
    wr(8'h45, 8'h0F);
    wr(8'h42, 8'h44);
    sinkMasterEnable <= 1'b0;
    span(160, c);
    chk(c, 0);
    @(posedge sys_clk);
    sinkMasterEnable <= 1'b1;
    controllerOn <= 1'b0;
    span(160, c);
    chk(c, 0);
    @(posedge sys_clk);
    controllerOn <= 1'b1;
    span(4, c);
    span(160, c);
    chk(c, 160);
    // Duty change mid-period waits for the boundary
    wr(8'h42, 8'h00);
    wr(8'h45, 8'h00);
    wr(8'h42, 8'h44);
    repeat (60) @(posedge sys_clk);
    wr(8'h45, 8'h0F);
    @(posedge sys_clk);
    #1 chk(sinkOn, 1'b0);
    repeat (200) @(posedge sys_clk);
    #1 chk(sinkOn, 1'b1);
    // Second reset in mid-run
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1 chk({chanTwoRangeCode, chanTwoPhaseInvert, chanTwoBrightnessCode}, 8'h04);
    chk({chanTwoPeriodCode, chanTwoDutyCode}, 8'h0F);
    chk(sinkOn, 1'b0);
    chk(regRdData, 8'h00);
    conclude();
  end
endmodule
